// File: pec_pkg.sv
// Constants for the PHY event, counter and self-test register bank.
// Assumes a 25 MHz register clock and word-indexed register offsets.
package pec_pkg;
  // ==========================================
  // Register indices (byte address = 4 x index)
  localparam logic [5:0] IDX_EV1 = 6'h12;
  localparam logic [5:0] IDX_EV2 = 6'h13;
  localparam logic [5:0] IDX_FC = 6'h14;
  localparam logic [5:0] IDX_RE = 6'h15;
  localparam logic [5:0] IDX_BT = 6'h16;
  localparam logic [5:0] IDX_MX = 6'h17;
  // ==========================================
  // Self-test control fields
  localparam int BT_MODE = 14;
  localparam int BT_TYPE = 13;
  localparam int BT_GEN = 12;
  localparam int BT_LOCK = 11;
  localparam int BT_LOSS = 10;
  localparam int BT_GACT = 9;
  localparam int BT_LPTX = 6;
  localparam int BT_LPB = 2;
  localparam logic [15:0] BT_RSV_RD = 16'h0100;
  // ==========================================
  // MAC interface control fields
  localparam int MX_RSV = 13;
  localparam int MX_RXD = 12;
  localparam int MX_TXD = 11;
  localparam int MX_R10 = 10;
  localparam int MX_RGMII = 9;
  localparam int MX_R8 = 8;
  localparam int MX_CLK = 7;
  localparam int MX_R6 = 6;
  localparam int MX_RMII = 5;
  localparam int MX_REV = 4;
  localparam int MX_OVF = 3;
  localparam int MX_UDF = 2;
  localparam logic [2:0] MX_RSV_RST = 3'h2;
  localparam logic [1:0] MX_EBUF_RST = 2'h1;
  // ==========================================
  // Counters and timing
  localparam logic [7:0] FC_HALF = 8'h7F;
  localparam logic [15:0] RE_HALF = 16'h7FFF;
  localparam logic [7:0] BIST_ERR_MAX = 8'hFF;
  localparam logic [4:0] PRBS_LOCK_CNT = 5'h07;
  localparam logic [6:0] PRBS_SEED = 7'h7F;
  localparam int RGMII_DLY_NS = 2;
  localparam int SINGLE_PKT_BITS = 12112;
  // ==========================================
  // Loopback select encodings
  localparam logic [3:0] LPB_SEL_PCS = 4'h1;
  localparam logic [3:0] LPB_SEL_ANA = 4'h2;
  localparam logic [3:0] LPB_SEL_REV = 4'h4;
  typedef enum logic [2:0] {
    PEC_LPB_NORMAL, PEC_LPB_PCS, PEC_LPB_ANALOG, PEC_LPB_REVERSE, PEC_LPB_RSVD
  } pec_lpb_t;
  typedef enum logic [1:0] {PEC_MII, PEC_RMII, PEC_RGMII} pec_mii_t;
endpackage

// File: pec_sat_cnt.sv
// Saturating clear-on-read event counter with a half-full event.
// Assumes one-cycle increment and clear strobes on the register clock.
`timescale 1ns/1ps
module pec_sat_cnt #(
  parameter int W = 8,
  parameter logic [W-1:0] HALF = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Strobes
  input wire logic inc_i,
  input wire logic clr_i,
  // Results
  output logic [W-1:0] cnt_o,
  output logic half_o
);
  import pec_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic half;
  } pec_cnt_t;
  pec_cnt_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.half = 1'b0;
    if (clr_i) begin
      // Event in the clearing cycle is kept
      s_next.cnt = W'(inc_i);
    end else if (inc_i && s_reg.cnt != '1) begin
      s_next.cnt = s_reg.cnt + W'(1);
      s_next.half = (s_reg.cnt == HALF);
    end
    if (rst_i) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign cnt_o = s_reg.cnt;
  assign half_o = s_reg.half;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sat_hold_a: assert property ((s_reg.cnt == '1 && !clr_i) |=> s_reg.cnt == '1)
    else $error("counter left saturation");
  half_once_a: assert property (s_reg.half |-> s_reg.cnt == HALF + W'(1))
    else $error("half event at wrong count");
endmodule

// File: pec_prbs.sv
// Self-test packet generator and PRBS7 checker.
// Assumes one bit per clock on both the transmit and receive streams.
`timescale 1ns/1ps
module pec_prbs #(
  parameter int PKT_BITS = pec_pkg::SINGLE_PKT_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic gen_en_i,
  input wire logic prbs_i,
  input wire logic cont_i,
  input wire logic rx_bit_i,
  // Status and stream
  output logic tx_bit_o,
  output logic tx_en_o,
  output logic gen_act_o,
  output logic lock_o,
  output logic loss_o,
  output logic wrap_o
);
  import pec_pkg::*;
  typedef struct packed {
    logic act;
    logic done;
    logic [15:0] bits;
    logic [6:0] lfsr;
    logic tx;
    logic [6:0] hist;
    logic [4:0] good;
    logic lock;
    logic loss;
    logic [7:0] err;
    logic wrap;
  } pec_prbs_t;
  pec_prbs_t s_reg, s_next;
  logic exp_bit;

  always_comb begin
    s_next = s_reg;
    s_next.loss = 1'b0;
    s_next.wrap = 1'b0;
    exp_bit = s_reg.hist[6] ^ s_reg.hist[5];
    // Generator
    if (!gen_en_i) begin
      s_next.act = 1'b0;
      s_next.done = 1'b0;
      s_next.bits = '0;
    end else if (prbs_i) begin
      s_next.act = 1'b1;
      s_next.lfsr = {s_reg.lfsr[5:0], s_reg.lfsr[6] ^ s_reg.lfsr[5]};
    end else if (!s_reg.done) begin
      // One constant-data packet, then idle until re-enabled
      s_next.act = 1'b1;
      s_next.bits = s_reg.bits + 16'h0001;
      if (s_reg.bits == 16'(PKT_BITS - 1)) begin
        s_next.done = 1'b1;
        s_next.act = 1'b0;
      end
    end else begin
      s_next.act = 1'b0;
    end
    s_next.tx = prbs_i ? s_reg.lfsr[6] : 1'b0;
    // Checker, active whenever PRBS type is chosen
    if (!prbs_i) begin
      s_next.lock = 1'b0;
      s_next.good = '0;
      s_next.hist = '0;
    end else begin
      s_next.hist = {s_reg.hist[5:0], rx_bit_i};
      if (exp_bit == rx_bit_i) begin
        if (!s_reg.lock) begin
          s_next.good = s_reg.good + 5'h01;
          s_next.lock = (s_reg.good == PRBS_LOCK_CNT - 5'h01);
        end
      end else begin
        s_next.good = '0;
        if (s_reg.lock) begin
          s_next.lock = 1'b0;
          s_next.loss = 1'b1;
          if (s_reg.err != BIST_ERR_MAX) begin
            s_next.err = s_reg.err + 8'h01;
          end else if (cont_i) begin
            s_next.err = '0;
            s_next.wrap = 1'b1;
          end
        end
      end
    end
    if (rst_i) begin
      s_next = '0;
      s_next.lfsr = PRBS_SEED;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign tx_bit_o = s_reg.tx;
  assign tx_en_o = s_reg.act;
  assign gen_act_o = s_reg.act;
  assign lock_o = s_reg.lock;
  assign loss_o = s_reg.loss;
  assign wrap_o = s_reg.wrap;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  gen_off_a: assert property (!gen_en_i |=> !gen_act_o)
    else $error("generator active while disabled");
  chk_off_a: assert property (!prbs_i |=> !lock_o)
    else $error("checker locked in constant mode");
  err_stop_a: assert property ((s_reg.err == BIST_ERR_MAX && !cont_i) |=>
    s_reg.err == BIST_ERR_MAX) else $error("single mode count moved past max");
endmodule

// File: pec_regs.sv
// Event, counter, self-test and MAC interface registers of a PHY.
// Assumes classic Wishbone on clk_i; event inputs are one-cycle pulses.
`timescale 1ns/1ps
module pec_regs #(
  parameter int PKT_BITS = pec_pkg::SINGLE_PKT_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Event pulses
  input wire logic undervolt_i,
  input wire logic overvolt_i,
  input wire logic overtemp_i,
  input wire logic sleep_i,
  input wire logic polarity_i,
  input wire logic jabber_i,
  input wire logic false_carrier_i,
  input wire logic rx_dv_i,
  input wire logic rx_er_i,
  input wire logic rx_fifo_ovf_i,
  input wire logic rx_fifo_udf_i,
  input wire logic bist_rx_i,
  // Straps
  input wire logic strap_rx_dly_i,
  input wire logic strap_tx_dly_i,
  input wire logic strap_rgmii_i,
  input wire logic strap_clk50_i,
  input wire logic strap_rmii_i,
  // Event outputs
  output logic int_o,
  output logic [7:0] event1_en_o,
  output logic fc_half_o,
  output logic re_half_o,
  // Self-test outputs
  output logic bist_tx_o,
  output logic bist_tx_en_o,
  output logic bist_err_wrap_o,
  output pec_pkg::pec_lpb_t lpb_mode_o,
  output logic lpb_mdi_tx_o,
  // MAC interface controls
  output logic rx_clk_dly_o,
  output logic tx_clk_dly_o,
  output pec_pkg::pec_mii_t mii_mode_o,
  output logic clk50_sel_o,
  output logic rmii_rev10_o,
  output logic [1:0] ebuf_size_o
);
  import pec_pkg::*;

  typedef struct packed {
    logic ack;
    logic [15:0] rdat;
    logic [7:0] en1;
    logic [5:0] st2;
    logic [5:0] en2;
    logic bmode;
    logic btype;
    logic bgen;
    logic bloss;
    logic [3:0] lpb;
    logic lptx;
    logic [1:0] brsv;
    logic [2:0] mrsv;
    logic rxd;
    logic txd;
    logic r10;
    logic rgmii;
    logic r8;
    logic clk50;
    logic r6;
    logic rmii;
    logic rev;
    logic ovf;
    logic udf;
    logic [1:0] ebuf;
    pec_lpb_t lmode;
    pec_mii_t mmode;
    logic intr;
  } pec_state_t;

  pec_state_t s_reg, s_next;

  // ==========================================
  // Bus decode
  logic take;
  logic rd;
  logic wr;
  logic [5:0] idx;
  logic [15:0] wd;
  logic [5:0] ev2;
  logic [5:0] st2_set;
  logic fc_clr;
  logic re_clr;
  logic re_inc;
  logic mac_lpb;
  logic [7:0] fc_cnt;
  logic [15:0] re_cnt;
  logic fc_half;
  logic re_half;
  logic gen_act;
  logic bist_lock;
  logic bist_loss;
  logic [3:0] lpb_w;

  assign take = wb_cyc_i & wb_stb_i & ~s_reg.ack;
  assign rd = take & ~wb_we_i;
  assign wr = take & wb_we_i;
  assign idx = wb_adr_i[7:2];
  assign wd = wb_dat_i[15:0];
  assign ev2 = {undervolt_i, overvolt_i, overtemp_i, sleep_i, polarity_i, jabber_i};
  assign fc_clr = rd & (idx == IDX_FC);
  assign re_clr = rd & (idx == IDX_RE);
  // PCS loopback is the loop that returns MAC transmit data
  assign mac_lpb = (s_reg.lpb == LPB_SEL_PCS);
  assign re_inc = rx_dv_i & rx_er_i & ~mac_lpb;
  assign lpb_w = wd[BT_LPB+3:BT_LPB];

  // ==========================================
  // Latched event flags, set beats read-clear
  for (genvar i = 0; i < 6; i++) begin : g_st2
    assign st2_set[i] = ev2[i] | (s_reg.st2[i] & ~(rd & (idx == IDX_EV2)));
  end

  // ==========================================
  // Counters and self-test engine
  pec_sat_cnt #(.W(8), .HALF(FC_HALF)) u_fc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(false_carrier_i),
    .clr_i(fc_clr),
    .cnt_o(fc_cnt),
    .half_o(fc_half)
  );

  pec_sat_cnt #(.W(16), .HALF(RE_HALF)) u_re (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(re_inc),
    .clr_i(re_clr),
    .cnt_o(re_cnt),
    .half_o(re_half)
  );

  pec_prbs #(.PKT_BITS(PKT_BITS)) u_prbs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .gen_en_i(s_reg.bgen),
    .prbs_i(s_reg.btype),
    .cont_i(s_reg.bmode),
    .rx_bit_i(bist_rx_i),
    .tx_bit_o(bist_tx_o),
    .tx_en_o(bist_tx_en_o),
    .gen_act_o(gen_act),
    .lock_o(bist_lock),
    .loss_o(bist_loss),
    .wrap_o(bist_err_wrap_o)
  );

  assign fc_half_o = fc_half;
  assign re_half_o = re_half;

  // ==========================================
  // Register update
  always_comb begin
    s_next = s_reg;
    s_next.ack = take;
    s_next.st2 = st2_set;
    // Sticky loss; a new loss in the read cycle survives
    s_next.bloss = bist_loss | (s_reg.bloss & ~(rd & (idx == IDX_BT)));
    s_next.ovf = rx_fifo_ovf_i | (s_reg.ovf & ~(rd & (idx == IDX_MX)));
    s_next.udf = rx_fifo_udf_i | (s_reg.udf & ~(rd & (idx == IDX_MX)));
    s_next.rdat = '0;
    if (rd) begin
      unique case (idx)
        IDX_EV1: s_next.rdat = {8'h00, s_reg.en1};
        IDX_EV2: s_next.rdat = {s_reg.st2[5:4], 2'b00, s_reg.st2[3:0],
                                s_reg.en2[5:4], 2'b00, s_reg.en2[3:0]};
        IDX_FC: s_next.rdat = {8'h00, fc_cnt};
        IDX_RE: s_next.rdat = re_cnt;
        IDX_BT: begin
          s_next.rdat = BT_RSV_RD;
          s_next.rdat[BT_MODE] = s_reg.bmode;
          s_next.rdat[BT_TYPE] = s_reg.btype;
          s_next.rdat[BT_GEN] = s_reg.bgen;
          s_next.rdat[BT_LOCK] = bist_lock;
          s_next.rdat[BT_LOSS] = s_reg.bloss;
          s_next.rdat[BT_GACT] = gen_act;
          s_next.rdat[BT_LPTX] = s_reg.lptx;
          s_next.rdat[BT_LPB+3:BT_LPB] = s_reg.lpb;
          s_next.rdat[1:0] = s_reg.brsv;
        end
        IDX_MX: begin
          s_next.rdat[15:MX_RSV] = s_reg.mrsv;
          s_next.rdat[MX_RXD] = s_reg.rxd;
          s_next.rdat[MX_TXD] = s_reg.txd;
          s_next.rdat[MX_R10] = s_reg.r10;
          s_next.rdat[MX_RGMII] = s_reg.rgmii;
          s_next.rdat[MX_R8] = s_reg.r8;
          s_next.rdat[MX_CLK] = s_reg.clk50;
          s_next.rdat[MX_R6] = s_reg.r6;
          s_next.rdat[MX_RMII] = s_reg.rmii;
          s_next.rdat[MX_REV] = s_reg.rev;
          // Status bits read 1 while normal
          s_next.rdat[MX_OVF] = ~s_reg.ovf;
          s_next.rdat[MX_UDF] = ~s_reg.udf;
          s_next.rdat[1:0] = s_reg.ebuf;
        end
        default: s_next.rdat = '0;
      endcase
    end
    if (wr && wb_sel_i[0]) begin
      unique case (idx)
        IDX_EV1: s_next.en1 = wd[7:0];
        IDX_EV2: s_next.en2 = {wd[7:6], wd[3:0]};
        IDX_BT: begin
          s_next.lpb = lpb_w;
          // Line transmit only accepted together with MAC loopback
          s_next.lptx = wd[BT_LPTX] & (lpb_w == LPB_SEL_PCS);
          s_next.brsv = wd[1:0];
        end
        IDX_MX: begin
          s_next.clk50 = wd[MX_CLK];
          s_next.r6 = wd[MX_R6];
          s_next.rmii = wd[MX_RMII];
          s_next.rev = wd[MX_REV];
          s_next.ebuf = wd[1:0];
        end
        default: s_next.rdat = s_next.rdat;
      endcase
    end
    if (wr && wb_sel_i[1]) begin
      unique case (idx)
        IDX_BT: begin
          s_next.bmode = wd[BT_MODE];
          s_next.btype = wd[BT_TYPE];
          s_next.bgen = wd[BT_GEN];
        end
        IDX_MX: begin
          s_next.mrsv = wd[15:MX_RSV];
          s_next.rxd = wd[MX_RXD];
          s_next.txd = wd[MX_TXD];
          s_next.r10 = wd[MX_R10];
          s_next.rgmii = wd[MX_RGMII];
          s_next.r8 = wd[MX_R8];
        end
        default: s_next.rdat = s_next.rdat;
      endcase
    end
    // Loopback decode; codes 0, 1, 2 and 4 only, others reserved
    unique case (s_next.lpb)
      4'h0: s_next.lmode = PEC_LPB_NORMAL;
      LPB_SEL_PCS: s_next.lmode = PEC_LPB_PCS;
      LPB_SEL_ANA: s_next.lmode = PEC_LPB_ANALOG;
      LPB_SEL_REV: s_next.lmode = PEC_LPB_REVERSE;
      default: s_next.lmode = PEC_LPB_RSVD;
    endcase
    s_next.mmode = s_next.rgmii ? PEC_RGMII :
                   (s_next.rmii ? PEC_RMII : PEC_MII);
    s_next.intr = |(s_next.st2 & s_next.en2);
    if (rst_i) begin
      s_next = '0;
      s_next.lmode = PEC_LPB_NORMAL;
      s_next.mrsv = MX_RSV_RST;
      s_next.r6 = 1'b1;
      s_next.ebuf = MX_EBUF_RST;
      // Straps caught while reset is held
      s_next.rxd = strap_rx_dly_i;
      s_next.txd = strap_tx_dly_i;
      s_next.rgmii = strap_rgmii_i;
      s_next.clk50 = strap_clk50_i;
      s_next.rmii = strap_rmii_i;
      s_next.mmode = strap_rgmii_i ? PEC_RGMII : (strap_rmii_i ? PEC_RMII : PEC_MII);
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  // ==========================================
  // Outputs
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = {16'h0000, s_reg.rdat};
  assign int_o = s_reg.intr;
  assign event1_en_o = s_reg.en1;
  assign lpb_mode_o = s_reg.lmode;
  assign lpb_mdi_tx_o = s_reg.lptx;
  assign rx_clk_dly_o = s_reg.rxd;
  assign tx_clk_dly_o = s_reg.txd;
  assign mii_mode_o = s_reg.mmode;
  assign clk50_sel_o = s_reg.clk50;
  assign rmii_rev10_o = s_reg.rev;
  assign ebuf_size_o = s_reg.ebuf;

  // ==========================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  en_reset_a: assert property ($fell(rst_i) |->
    event1_en_o == 8'h00 && s_reg.en2 == 6'h00) else $error("enables not zero after reset");
  flag_set_a: assert property (undervolt_i |=> s_reg.st2[5] ##1 s_reg.st2[5] || $past(rd))
    else $error("undervoltage flag not latched");
  rsv_zero_a: assert property ((rd && idx == IDX_EV2) |=>
    wb_dat_o[13:12] == 2'b00 && wb_dat_o[5:4] == 2'b00) else $error("reserved bits not zero");
  flag_cor_a: assert property ((rd && idx == IDX_EV2 && ev2 == 6'h00) |=>
    s_reg.st2 == 6'h00) else $error("flags not cleared by read");
  fc_cor_a: assert property ((fc_clr && !false_carrier_i) |=> fc_cnt == 8'h00)
    else $error("false carrier count not cleared");
  re_inc_a: assert property ((re_inc && !re_clr && re_cnt != 16'hFFFF) |=>
    re_cnt == $past(re_cnt) + 16'h0001) else $error("receive error count missed");
  re_lpb_a: assert property ((mac_lpb && !re_clr) |=> re_cnt == $past(re_cnt))
    else $error("count moved in loopback");
  lptx_gate_a: assert property (lpb_mdi_tx_o |-> lpb_mode_o == PEC_LPB_PCS)
    else $error("line transmit outside loopback");
  mii_mode_a: assert property (mii_mode_o == (s_reg.rgmii ? PEC_RGMII :
    (s_reg.rmii ? PEC_RMII : PEC_MII))) else $error("interface mode wrong");
  int_out_a: assert property ((|(s_reg.st2 & s_reg.en2)) && !(take && idx == IDX_EV2) |=>
    int_o) else $error("interrupt not raised");
  ovf_show_a: assert property ((rx_fifo_ovf_i && !(rd && idx == IDX_MX)) |=> ##1
    (rd && idx == IDX_MX) |=> !wb_dat_o[MX_OVF]) else $error("overflow not shown");
  fc_half_c: cover property (fc_half_o);
  re_half_c: cover property (re_half_o);
  lock_c: cover property (bist_lock ##1 !bist_lock);
  int_c: cover property (int_o ##1 !int_o);
endmodule

// File: pec_regs_test.sv
// Self-checking bench for the event, counter, self-test and MAC control registers.
// Assumes pec_pkg and pec_regs are compiled first; the bench is the Wishbone master.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
module pec_regs_test;
  import pec_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [7:0] ev = 8'h00;
  logic [4:0] strap = 5'h12;
  logic fc = 1'b0;
  logic dv = 1'b0;
  logic er = 1'b0;
  logic brx = 1'b0;
  logic flip = 1'b0;
  logic wrap;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, int_o, fc_half_o, re_half_o, bist_tx_o, bist_tx_en_o, lpb_mdi_tx_o;
  logic rx_clk_dly_o, tx_clk_dly_o, clk50_sel_o, rmii_rev10_o;
  logic [1:0] ebuf_size_o;
  logic [7:0] event1_en_o;
  pec_lpb_t lpb_mode_o;
  pec_mii_t mii_mode_o;
  int miscompares = 0;
  int samples_checked = 0;
  int fch = 0;
  int reh = 0;
  int wrp = 0;
  logic [15:0] lsel [5] = '{16'h0000, 16'h0004, 16'h0008, 16'h0010, 16'h0020};
  pec_lpb_t lexp [5] = '{PEC_LPB_NORMAL, PEC_LPB_PCS, PEC_LPB_ANALOG, PEC_LPB_REVERSE,
    PEC_LPB_RSVD};
  always #20 clk_i = ~clk_i;
  // Generated stream looped back, with an optional bit error
  always @(posedge clk_i) begin
    brx <= bist_tx_o ^ flip;
    if (fc_half_o === 1'b1) fch++;
    if (re_half_o === 1'b1) reh++;
    if (wrap === 1'b1) wrp++;
  end
  // ==========================================
  // Design under test
  pec_regs #(.PKT_BITS(32)) dut_u (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o,
    .undervolt_i(ev[5]), .overvolt_i(ev[4]), .overtemp_i(ev[3]), .sleep_i(ev[2]),
    .polarity_i(ev[1]), .jabber_i(ev[0]), .false_carrier_i(fc), .rx_dv_i(dv),
    .rx_er_i(er), .rx_fifo_ovf_i(ev[7]), .rx_fifo_udf_i(ev[6]), .bist_rx_i(brx),
    .strap_rx_dly_i(strap[4]), .strap_tx_dly_i(strap[3]), .strap_rgmii_i(strap[2]),
    .strap_clk50_i(strap[1]), .strap_rmii_i(strap[0]), .int_o, .event1_en_o,
    .fc_half_o, .re_half_o, .bist_tx_o, .bist_tx_en_o, .bist_err_wrap_o(wrap),
    .lpb_mode_o, .lpb_mdi_tx_o, .rx_clk_dly_o, .tx_clk_dly_o, .mii_mode_o,
    .clk50_sel_o, .rmii_rev10_o, .ebuf_size_o);
  // ==========================================
  // Bus and helper tasks
  task automatic wb(input logic [5:0] i, input logic w, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    logic [15:0] q;
    wb(i, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [5:0] i, input logic [15:0] e);
    logic [15:0] q;
    wb(i, 1'b0, 16'h0000, q);
    `CHK(q, e)
  endtask
  task automatic evp(input logic [7:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 8'h00;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One flipped bit per repetition, spaced so the checker relocks in between
  task automatic lose(input int n);
    repeat (n) begin
      tick(20);
      flip <= 1'b1;
      tick(1);
      flip <= 1'b0;
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================
  // Test sequence
  initial begin
    tick(2);
    rst_i <= 1'b0;
    rdc(IDX_EV1, 16'h0000);
    rdc(IDX_EV2, 16'h0000);
    rdc(IDX_FC, 16'h0000);
    rdc(IDX_RE, 16'h0000);
    rdc(IDX_BT, 16'h0100);
    rdc(IDX_MX, 16'h50CD);
    rdc(6'h20, 16'h0000);
    wr(IDX_EV1, 16'h00A5);
    rdc(IDX_EV1, 16'h00A5);
    `CHK(event1_en_o, 8'hA5)
    // Enabled flags raise the interrupt; masked ones only latch
    wr(IDX_EV2, 16'hFFFF);
    rdc(IDX_EV2, 16'h00CF);
    evp(8'h21);
    tick(3);
    `CHK(int_o, 1'b1)
    rdc(IDX_EV2, 16'h81CF);
    rdc(IDX_EV2, 16'h00CF);
    `CHK(int_o, 1'b0)
    wr(IDX_EV2, 16'h0000);
    evp(8'h1E);
    tick(3);
    `CHK(int_o, 1'b0)
    rdc(IDX_EV2, 16'h4E00);
    fc <= 1'b1;
    tick(128);
    fc <= 1'b0;
    tick(3);
    rdc(IDX_FC, 16'h0080);
    `CHK(fch, 1)
    rdc(IDX_FC, 16'h0000);
    fc <= 1'b1;
    tick(300);
    fc <= 1'b0;
    rdc(IDX_FC, 16'h00FF);
    // Errors count only with valid data, never in MAC-side loopback
    er <= 1'b1;
    tick(5);
    dv <= 1'b1;
    tick(5);
    dv <= 1'b0;
    er <= 1'b0;
    rdc(IDX_RE, 16'h0005);
    wr(IDX_BT, 16'h0004);
    dv <= 1'b1;
    er <= 1'b1;
    tick(10);
    dv <= 1'b0;
    er <= 1'b0;
    rdc(IDX_RE, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      wr(IDX_BT, lsel[k]);
      rdc(IDX_BT, lsel[k] | 16'h0100);
      `CHK(lpb_mode_o, lexp[k])
    end
    wr(IDX_BT, 16'h0044);
    `CHK(lpb_mdi_tx_o, 1'b1)
    wr(IDX_BT, 16'h0048);
    rdc(IDX_BT, 16'h0108);
    wr(IDX_BT, 16'h1000);
    tick(5);
    `CHK(bist_tx_en_o, 1'b1)
    tick(60);
    rdc(IDX_BT, 16'h1100);
    wr(IDX_BT, 16'h3000);
    tick(40);
    rdc(IDX_BT, 16'h3B00);
    flip <= 1'b1;
    tick(1);
    flip <= 1'b0;
    tick(30);
    rdc(IDX_BT, 16'h3F00);
    rdc(IDX_BT, 16'h3B00);
    // Single mode holds the error count at its top; continuous mode then wraps it
    lose(256);
    tick(20);
    `CHK(wrp, 0)
    wr(IDX_BT, 16'h7000);
    lose(1);
    tick(20);
    `CHK(wrp, 1)
    rdc(IDX_BT, 16'h7F00);
    wr(IDX_BT, 16'h0000);
    tick(2);
    `CHK(bist_tx_en_o, 1'b0)
    wr(IDX_MX, 16'h1A93);
    rdc(IDX_MX, 16'h1A9F);
    `CHK(mii_mode_o, PEC_RGMII)
    `CHK({rx_clk_dly_o, tx_clk_dly_o, clk50_sel_o, rmii_rev10_o, ebuf_size_o}, 6'h3F)
    wr(IDX_MX, 16'h0020);
    tick(1);
    `CHK(mii_mode_o, PEC_RMII)
    `CHK(rmii_rev10_o, 1'b0)
    evp(8'h80);
    rdc(IDX_MX, 16'h0024);
    rdc(IDX_MX, 16'h002C);
    evp(8'h40);
    rdc(IDX_MX, 16'h0028);
    // Long run to saturation; the half-full event must fire once
    dv <= 1'b1;
    er <= 1'b1;
    tick(70000);
    dv <= 1'b0;
    er <= 1'b0;
    tick(3);
    `CHK(reh, 1)
    rdc(IDX_RE, 16'hFFFF);
    rst_i <= 1'b1;
    strap <= 5'h0D;
    tick(2);
    rst_i <= 1'b0;
    rdc(IDX_MX, 16'h4A6D);
    rdc(IDX_EV1, 16'h0000);
    finish_test;
  end
  // Hang guard: the full sequence needs about 76000 cycles
  initial begin
    tick(90000);
    miscompares++;
    finish_test;
  end
endmodule
